// ---- shared/rsc_regs.svh ----
// Purpose: Register offsets, field positions, codes and timing for the command block
// Assumes: Included by the package user files by bare name
// Notes: Offsets are word indices on the plain register port
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RSC_OFF_ERROR 4'h1
`define RSC_OFF_FEATURE 4'h1
`define RSC_OFF_SECCNT 4'h2
`define RSC_OFF_SECNUM 4'h3
`define RSC_OFF_CYLLO 4'h4
`define RSC_OFF_CYLHI 4'h5
`define RSC_OFF_DEVHEAD 4'h6
`define RSC_OFF_STATUS 4'h7
`define RSC_OFF_COMMAND 4'h7
`define RSC_OFF_CTRL 4'h8
`define RSC_OFF_IRQ_STAT 4'h9
`define RSC_OFF_IRQ_MASK 4'ha
`define RSC_OFF_STBY 4'hb

// ****************************************
// Field positions
// ****************************************
`define RSC_ST_BUSY 7
`define RSC_ST_DRIVE_READY_FLAG 6
`define RSC_ST_FAULT 5
`define RSC_ST_DRQ 3
`define RSC_ST_ERR 0
`define RSC_ER_ABORT_FLAG 2
`define RSC_DH_DEV 4
`define RSC_CT_SMART_EN 0
`define RSC_CT_SMART_SUP 1
`define RSC_CT_SAVE_SUP 2
`define RSC_CT_PM_SUP 3
`define RSC_CT_PACKET 4
`define RSC_CT_THRESH 5
`define RSC_CT_FAULT 6

// ****************************************
// Codes and reset values
// ****************************************
`define RSC_CMD_SMART 8'hb0
`define RSC_CMD_STANDBY 8'he2
`define RSC_FEAT_STATUS 8'hda
`define RSC_FEAT_SAVE 8'hd3
`define RSC_KEY_LO 8'h4f
`define RSC_KEY_HI 8'hc2
`define RSC_BAD_LO 8'hf4
`define RSC_BAD_HI 8'h2c
`define RSC_CTRL_RST 8'h0f
`define RSC_STATUS_RST 8'h40

// ****************************************
// Timing
// ****************************************
`define RSC_SAVE_NS 64
`define RSC_CLK_NS 8
`define RSC_SAVE_CYC ((`RSC_SAVE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)

`endif

// ---- shared/rsc_pkg.sv ----
// Purpose: Types shared by the command block
// Assumes: Constants live in rsc_regs.svh
// Notes: None
package rsc_pkg;

  typedef enum logic [3:0] {
    RSC_IDLE = 4'b0001,
    RSC_EXEC = 4'b0010,
    RSC_SAVE = 4'b0100,
    RSC_DONE = 4'b1000
  } rsc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsc_bus_t;

  typedef struct packed {
    rsc_state_t st;
    logic [7:0] cmd;
    logic [7:0] feat;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [7:0] devhead;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic standby;
    logic stby_en;
    logic [31:0] stby_cycles;
    logic [7:0] save_cnt;
    logic nv_save;
    logic [7:0] rdata;
  } rsc_state_s_t;

endpackage

// ---- rtl/rsc_cmd.sv ----
// Purpose: Executes reliability status, attribute save and standby commands
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Standby period is the sector count times the STBY_UNIT_CYC parameter
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "rsc_regs.svh"

// Notes on behaviour
// - Status good loads cylinder 4Fh and C2h
// - Threshold exceeded loads cylinder F4h and 2Ch
// - B0h with feature D3h saves attributes
// - Abort when unsupported, disabled or bad inputs
// - Abort allowed when action cannot complete
// - Abort ends busy, drq low, ready, err
// - Status done clears busy, fault, drq, err
// - Save and standby done clear busy, fault, drq
// - Save writes attributes at once to storage
// - Packet devices refuse attribute save command
// - Standby E2h takes period from sector count
// - Power management devices support standby command
// - Device select bit always shows selected device
// - B0h with feature DAh reports status
// - Standby enters mode, timer on when nonzero
module rsc_cmd
  import rsc_pkg::*;
#(
  parameter logic [31:0] STBY_UNIT_CYC = 32'd625000
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic IRQ,
  output logic NV_SAVE,
  output logic STANDBY,
  output logic STBY_TIMER_EN,
  output logic [31:0] STBY_PERIOD
);

  rsc_state_s_t s_q;
  rsc_state_s_t s_d;
  rsc_bus_t bus;
  logic keys_ok;
  logic abort;
  logic fault_now;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // ****************************************
  // Standby period lookup
  // ****************************************
  function automatic logic [31:0] stby_lookup(input logic [7:0] cnt);
    stby_lookup = 32'(cnt) * STBY_UNIT_CYC;
  endfunction

  assign keys_ok = (s_q.cyllo == `RSC_KEY_LO) && (s_q.cylhi == `RSC_KEY_HI);
  assign fault_now = s_q.ctrl[`RSC_CT_FAULT];

  // ****************************************
  // Abort decision for the latched command
  // ****************************************
  always_comb begin
    abort = 1'b1;
    if (s_q.cmd == `RSC_CMD_SMART) begin
      if (s_q.ctrl[`RSC_CT_SMART_SUP] && s_q.ctrl[`RSC_CT_SMART_EN] && keys_ok) begin
        if (s_q.feat == `RSC_FEAT_STATUS) begin
          abort = 1'b0;
        end else if (s_q.feat == `RSC_FEAT_SAVE) begin
          abort = !s_q.ctrl[`RSC_CT_SAVE_SUP] || s_q.ctrl[`RSC_CT_PACKET];
        end
      end
    end else if (s_q.cmd == `RSC_CMD_STANDBY) begin
      abort = !s_q.ctrl[`RSC_CT_PM_SUP];
    end
    abort = abort || fault_now;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.nv_save = 1'b0;
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `RSC_OFF_ERROR: s_d.rdata = s_q.error;
        `RSC_OFF_SECCNT: s_d.rdata = s_q.seccnt;
        `RSC_OFF_SECNUM: s_d.rdata = s_q.secnum;
        `RSC_OFF_CYLLO: s_d.rdata = s_q.cyllo;
        `RSC_OFF_CYLHI: s_d.rdata = s_q.cylhi;
        `RSC_OFF_DEVHEAD: s_d.rdata = s_q.devhead;
        `RSC_OFF_STATUS: s_d.rdata = s_q.status;
        `RSC_OFF_CTRL: s_d.rdata = s_q.ctrl;
        `RSC_OFF_IRQ_STAT: begin
          s_d.rdata = {5'h00, s_q.irq_stat};
          // Cleared ahead of the events below, so a same-cycle set wins
          s_d.irq_stat = 3'h0;
        end
        `RSC_OFF_IRQ_MASK: s_d.rdata = {5'h00, s_q.irq_mask};
        `RSC_OFF_STBY: s_d.rdata = {6'h00, s_q.stby_en, s_q.standby};
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (bus.wr) begin
      unique case (bus.addr)
        `RSC_OFF_FEATURE: s_d.feat = bus.wdata;
        `RSC_OFF_SECCNT: s_d.seccnt = bus.wdata;
        `RSC_OFF_SECNUM: s_d.secnum = bus.wdata;
        `RSC_OFF_CYLLO: s_d.cyllo = bus.wdata;
        `RSC_OFF_CYLHI: s_d.cylhi = bus.wdata;
        `RSC_OFF_DEVHEAD: s_d.devhead = bus.wdata;
        `RSC_OFF_CTRL: s_d.ctrl = bus.wdata;
        `RSC_OFF_IRQ_MASK: s_d.irq_mask = bus.wdata[2:0];
        `RSC_OFF_COMMAND: begin
          if (s_q.st == RSC_IDLE) begin
            s_d.cmd = bus.wdata;
            s_d.status[`RSC_ST_BUSY] = 1'b1;
            s_d.st = RSC_EXEC;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (s_q.st)
      RSC_IDLE: begin
      end
      RSC_EXEC: begin
        s_d.error = 8'h00;
        if (abort) begin
          s_d.error[`RSC_ER_ABORT_FLAG] = 1'b1;
          s_d.status[`RSC_ST_FAULT] = fault_now;
          s_d.status[`RSC_ST_ERR] = 1'b1;
          s_d.irq_stat[1] = 1'b1;
          s_d.st = RSC_DONE;
        end else if (s_q.cmd == `RSC_CMD_STANDBY) begin
          s_d.standby = 1'b1;
          s_d.stby_en = (s_q.seccnt != 8'h00);
          s_d.stby_cycles = stby_lookup(s_q.seccnt);
          s_d.status[`RSC_ST_FAULT] = 1'b0;
          s_d.status[`RSC_ST_ERR] = 1'b0;
          s_d.irq_stat[2] = 1'b1;
          s_d.st = RSC_DONE;
        end else if (s_q.feat == `RSC_FEAT_SAVE) begin
          s_d.nv_save = 1'b1;
          s_d.save_cnt = 8'(`RSC_SAVE_CYC);
          s_d.st = RSC_SAVE;
        end else begin
          if (s_q.ctrl[`RSC_CT_THRESH]) begin
            s_d.cyllo = `RSC_BAD_LO;
            s_d.cylhi = `RSC_BAD_HI;
          end else begin
            s_d.cyllo = `RSC_KEY_LO;
            s_d.cylhi = `RSC_KEY_HI;
          end
          s_d.status[`RSC_ST_FAULT] = 1'b0;
          s_d.status[`RSC_ST_ERR] = 1'b0;
          s_d.irq_stat[0] = 1'b1;
          s_d.st = RSC_DONE;
        end
      end
      RSC_SAVE: begin
        if (s_q.save_cnt <= 8'h01) begin
          s_d.status[`RSC_ST_FAULT] = 1'b0;
          s_d.status[`RSC_ST_ERR] = 1'b0;
          s_d.irq_stat[0] = 1'b1;
          s_d.st = RSC_DONE;
        end else begin
          s_d.save_cnt = s_q.save_cnt - 8'h01;
        end
      end
      RSC_DONE: begin
        s_d.status[`RSC_ST_BUSY] = 1'b0;
        s_d.status[`RSC_ST_DRQ] = 1'b0;
        s_d.status[`RSC_ST_DRIVE_READY_FLAG] = 1'b1;
        s_d.st = RSC_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_q <= '0;
      s_q.st <= RSC_IDLE;
      s_q.ctrl <= `RSC_CTRL_RST;
      s_q.status <= `RSC_STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign IRQ = |(s_q.irq_stat & s_q.irq_mask);
  assign NV_SAVE = s_q.nv_save;
  assign STANDBY = s_q.standby;
  assign STBY_TIMER_EN = s_q.stby_en;
  assign STBY_PERIOD = s_q.stby_cycles;

  // ****************************************
  // Checks
  // ****************************************
  a_good_status: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_SMART &&
     s_q.feat == `RSC_FEAT_STATUS && !s_q.ctrl[`RSC_CT_THRESH])
    |=> (s_q.cyllo == 8'h4f && s_q.cylhi == 8'hc2))
    else $error("Good status code wrong");
  a_bad_status: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_SMART &&
     s_q.feat == `RSC_FEAT_STATUS && s_q.ctrl[`RSC_CT_THRESH])
    |=> (s_q.cyllo == 8'hf4 && s_q.cylhi == 8'h2c))
    else $error("Threshold code wrong");
  a_save_pulse: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_SMART &&
     s_q.feat == `RSC_FEAT_SAVE) |=> NV_SAVE)
    else $error("Save not started");
  a_packet_refuse: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_SMART && s_q.feat == `RSC_FEAT_SAVE &&
     s_q.ctrl[`RSC_CT_PACKET]) |=> s_q.error[2] ##1 (s_q.status[0] && !s_q.status[7]))
    else $error("Packet device accepted save");
  a_abort_flags: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_SMART && !s_q.ctrl[`RSC_CT_SMART_EN])
    |=> s_q.error[2])
    else $error("Disabled monitoring not aborted");
  a_done_status: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_DONE && !s_q.error[2])
    |=> (s_q.status[7:6] == 2'b01 && !s_q.status[5] && !s_q.status[3] && !s_q.status[0]))
    else $error("Normal completion status wrong");
  a_abort_status: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_DONE && s_q.error[2])
    |=> (s_q.status[7:6] == 2'b01 && s_q.status[0] && !s_q.status[3]))
    else $error("Abort status wrong");
  a_stby_timer: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_STANDBY)
    |=> (STANDBY && STBY_TIMER_EN == ($past(s_q.seccnt) != 8'h00)))
    else $error("Standby timer state wrong");
  a_save_done: assert property (@(posedge CLK) disable iff (SRST)
    (NV_SAVE) |-> ##[1:12] (s_q.st == RSC_IDLE && !s_q.status[7] && !s_q.status[5]))
    else $error("Save never completed");

  // ****************************************
  // Decode and abort checks
  // ****************************************
  a_save_decode: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_SMART &&
     s_q.feat == `RSC_FEAT_SAVE)
    |=> (s_q.st == RSC_SAVE && s_q.status[`RSC_ST_BUSY]))
    else $error("Save command not decoded");

  a_status_decode: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_SMART &&
     s_q.feat == `RSC_FEAT_STATUS)
    |=> (s_q.st == RSC_DONE && !NV_SAVE))
    else $error("Status command not decoded");

  a_bad_keys: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_SMART &&
     (s_q.cyllo != 8'h4f || s_q.cylhi != 8'hc2))
    |=> s_q.error[`RSC_ER_ABORT_FLAG])
    else $error("Bad cylinder key not aborted");

  a_bad_feature: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_SMART &&
     s_q.feat != `RSC_FEAT_STATUS && s_q.feat != `RSC_FEAT_SAVE)
    |=> s_q.error[`RSC_ER_ABORT_FLAG])
    else $error("Bad feature not aborted");

  a_smart_unsup: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_SMART && !s_q.ctrl[`RSC_CT_SMART_SUP])
    |=> s_q.error[`RSC_ER_ABORT_FLAG])
    else $error("Unsupported command not aborted");

  a_save_unsup: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_SMART && s_q.feat == `RSC_FEAT_SAVE &&
     !s_q.ctrl[`RSC_CT_SAVE_SUP])
    |=> s_q.error[`RSC_ER_ABORT_FLAG])
    else $error("Unsupported save not aborted");

  a_fault_abort: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.ctrl[`RSC_CT_FAULT])
    |=> (s_q.error[`RSC_ER_ABORT_FLAG] && s_q.status[`RSC_ST_FAULT]))
    else $error("Fault not reported");

  a_pm_refuse: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd == `RSC_CMD_STANDBY && !s_q.ctrl[`RSC_CT_PM_SUP])
    |=> (s_q.error[`RSC_ER_ABORT_FLAG] && $stable(STBY_PERIOD)))
    else $error("Standby without power management not aborted");

  a_cyl_on_abort: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && abort && !bus.wr)
    |=> ($stable(s_q.cyllo) && $stable(s_q.cylhi)))
    else $error("Abort changed cylinder values");

  a_cyl_untouched: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.feat != `RSC_FEAT_STATUS && !bus.wr)
    |=> ($stable(s_q.cyllo) && $stable(s_q.cylhi)))
    else $error("Cylinder values changed by another command");

  // ****************************************
  // Completion status checks
  // ****************************************
  a_abort_clean: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && abort && !s_q.ctrl[`RSC_CT_FAULT])
    |=> !s_q.status[`RSC_ST_FAULT])
    else $error("Fault shown without a fault");

  a_err_mirror: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.error != 8'h00) |-> s_q.status[`RSC_ST_ERR])
    else $error("Error bit not mirrored");

  a_abort_word: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_DONE && s_q.error[`RSC_ER_ABORT_FLAG])
    |=> ((s_q.status & 8'hdf) == 8'h41))
    else $error("Abort status word wrong");

  a_status_word: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_DONE && s_q.error == 8'h00)
    |=> (s_q.status == 8'h40))
    else $error("Normal status word wrong");

  a_busy_tracks: assert property (@(posedge CLK) disable iff (SRST)
    s_q.status[`RSC_ST_BUSY] == (s_q.st != RSC_IDLE))
    else $error("Busy does not follow the command");

  a_ready_after: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_DONE) |=> s_q.status[`RSC_ST_DRIVE_READY_FLAG])
    else $error("Ready not set at completion");

  // ****************************************
  // Attribute save checks
  // ****************************************
  a_save_once: assert property (@(posedge CLK) disable iff (SRST)
    NV_SAVE |=> !NV_SAVE)
    else $error("Save pulse too long");

  a_save_source: assert property (@(posedge CLK) disable iff (SRST)
    NV_SAVE |-> (s_q.st == RSC_SAVE && $past(s_q.st) == RSC_EXEC))
    else $error("Save pulse outside a save command");

  a_save_length: assert property (@(posedge CLK) disable iff (SRST)
    NV_SAVE |-> ##8 (s_q.st == RSC_DONE))
    else $error("Save time wrong");

  // ****************************************
  // Standby checks
  // ****************************************
  a_stby_period: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && !abort && s_q.cmd == `RSC_CMD_STANDBY)
    |=> (STBY_PERIOD == 32'($past(s_q.seccnt)) * STBY_UNIT_CYC))
    else $error("Standby period wrong");

  a_stby_kept: assert property (@(posedge CLK) disable iff (SRST)
    (s_q.st == RSC_EXEC && s_q.cmd != `RSC_CMD_STANDBY) |=> $stable(STBY_PERIOD))
    else $error("Standby period changed by another command");

  a_stby_sticky: assert property (@(posedge CLK) disable iff (SRST)
    STANDBY |=> STANDBY)
    else $error("Standby mode left");

  // ****************************************
  // Device select checks
  // ****************************************
  a_dev_kept: assert property (@(posedge CLK) disable iff (SRST)
    !(bus.wr && bus.addr == `RSC_OFF_DEVHEAD) |=> $stable(s_q.devhead))
    else $error("Device select changed without a write");

  a_dev_readback: assert property (@(posedge CLK) disable iff (SRST)
    (bus.rd && bus.addr == `RSC_OFF_DEVHEAD)
    |=> (RDATA[`RSC_DH_DEV] == $past(s_q.devhead[`RSC_DH_DEV])))
    else $error("Device select bit not read back");

endmodule

// ---- bench/rsc_host.sv ----
// Purpose: Host adapter model that writes and reads the task-file registers
// Assumes: Strobes change by non-blocking assignment right after a rising edge
// Notes: Write data is inverted once released so stale values never pass
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_host (
  input wire logic CLK,
  output logic [3:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [7:0] RDATA
);
  initial begin
    ADDR = 4'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    WDATA <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // Waits for ready and not busy, issues, then waits for completion
  task automatic cmd(input logic [7:0] c, output logic ok);
    logic [7:0] s;
    int n;
    ok = 1'b0;
    s = 8'h80;
    for (n = 0; n < 40 && (s[`RSC_ST_BUSY] !== 1'b0 || s[`RSC_ST_DRIVE_READY_FLAG] !== 1'b1); n++) begin
      rd(`RSC_OFF_STATUS, s);
    end
    if (n < 40) begin
      wr(`RSC_OFF_COMMAND, c);
      s = 8'h80;
      for (n = 0; n < 40 && s[`RSC_ST_BUSY] !== 1'b0; n++) begin
        rd(`RSC_OFF_STATUS, s);
      end
      ok = (n < 40);
    end
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the reliability and standby command block
// Assumes: Standby unit shortened to 4 cycles
// Notes: Expected values come from the command codes and status layout
`timescale 1ns/1ps
`include "rsc_regs.svh"
module tb_top;
  import rsc_pkg::*;
  localparam logic [31:0] UNIT = 32'd4;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA, v;
  logic WR, RD, IRQ, NV_SAVE, STANDBY, STBY_TIMER_EN, ok;
  logic [31:0] STBY_PERIOD;
  int n_fail = 0;
  int n_checks = 0;
  int nv_cnt = 0;
  int cyc = 0;

  always #4 CLK = ~CLK;

  rsc_host host (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  rsc_cmd #(.STBY_UNIT_CYC(UNIT)) dut_u (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .NV_SAVE(NV_SAVE),
    .STANDBY(STANDBY), .STBY_TIMER_EN(STBY_TIMER_EN), .STBY_PERIOD(STBY_PERIOD));

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (NV_SAVE === 1'b1) nv_cnt <= nv_cnt + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("FAIL t=%0t timeout", $time);
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // Presets capability control and inputs, issues a command, checks that it completes
  task automatic run(input logic [7:0] ct, input logic [7:0] ft, input logic [7:0] lo,
                     input logic [7:0] hi, input logic [7:0] sc, input logic [7:0] c);
    host.wr(`RSC_OFF_CTRL, ct);
    host.wr(`RSC_OFF_FEATURE, ft);
    host.wr(`RSC_OFF_SECCNT, sc);
    host.wr(`RSC_OFF_CYLLO, lo);
    host.wr(`RSC_OFF_CYLHI, hi);
    host.cmd(c, ok);
    chk(ok, 1'b1, "completion");
  endtask

  task automatic expect_end(input logic [7:0] st, input logic [7:0] er);
    host.rd(`RSC_OFF_STATUS, v);
    chk(v, st, "status");
    host.rd(`RSC_OFF_ERROR, v);
    chk(v, er, "error");
  endtask

  task automatic t_status;
    run(8'h0f, `RSC_FEAT_STATUS, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h40, 8'h00);
    host.rd(`RSC_OFF_CYLLO, v);
    chk(v, 8'h4f, "good lo");
    host.rd(`RSC_OFF_CYLHI, v);
    chk(v, 8'hc2, "good hi");
    run(8'h2f, `RSC_FEAT_STATUS, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    host.rd(`RSC_OFF_CYLLO, v);
    chk(v, 8'hf4, "bad lo");
    host.rd(`RSC_OFF_CYLHI, v);
    chk(v, 8'h2c, "bad hi");
    $display("test status done");
  endtask

  task automatic t_save;
    int c0;
    c0 = nv_cnt;
    run(8'h0f, `RSC_FEAT_SAVE, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    chk(nv_cnt - c0, 1, "save pulses");
    expect_end(8'h40, 8'h00);
    run(8'h1f, `RSC_FEAT_SAVE, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    chk(nv_cnt - c0, 1, "packet save");
    expect_end(8'h41, 8'h04);
    $display("test save done");
  endtask

  task automatic t_abort;
    run(8'h0f, `RSC_FEAT_STATUS, 8'h00, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h41, 8'h04);
    run(8'h0f, 8'h55, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h41, 8'h04);
    run(8'h0e, `RSC_FEAT_STATUS, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h41, 8'h04);
    run(8'h0d, `RSC_FEAT_SAVE, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h41, 8'h04);
    run(8'h0b, `RSC_FEAT_SAVE, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h41, 8'h04);
    run(8'h4f, `RSC_FEAT_STATUS, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    expect_end(8'h61, 8'h04);
    $display("test abort done");
  endtask

  task automatic t_standby;
    run(8'h07, 8'h00, 8'h00, 8'h00, 8'h03, `RSC_CMD_STANDBY);
    expect_end(8'h41, 8'h04);
    chk(STANDBY, 1'b0, "no pm standby");
    run(8'h0f, 8'h00, 8'h00, 8'h00, 8'h03, `RSC_CMD_STANDBY);
    expect_end(8'h40, 8'h00);
    chk({STANDBY, STBY_TIMER_EN}, 2'b11, "standby on");
    chk(STBY_PERIOD, 32'd3 * UNIT, "period");
    host.rd(`RSC_OFF_STBY, v);
    chk(v, 8'h03, "standby reg");
    run(8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, `RSC_CMD_STANDBY);
    chk({STANDBY, STBY_TIMER_EN}, 2'b10, "timer off");
    $display("test standby done");
  endtask

  task automatic t_irq_dev;
    host.rd(`RSC_OFF_IRQ_STAT, v);
    chk(v, 8'h07, "events so far");
    host.wr(`RSC_OFF_DEVHEAD, 8'h10);
    host.wr(`RSC_OFF_IRQ_MASK, 8'h00);
    run(8'h0f, `RSC_FEAT_STATUS, `RSC_KEY_LO, `RSC_KEY_HI, 8'h00, `RSC_CMD_SMART);
    chk(IRQ, 1'b0, "masked irq");
    host.wr(`RSC_OFF_IRQ_MASK, 8'h07);
    #1;
    chk(IRQ, 1'b1, "irq up");
    host.rd(`RSC_OFF_IRQ_STAT, v);
    chk(v, 8'h01, "irq status");
    chk(IRQ, 1'b0, "irq cleared");
    host.rd(`RSC_OFF_DEVHEAD, v);
    chk(v[`RSC_DH_DEV], 1'b1, "device bit");
    host.rd(4'hc, v);
    chk(v, 8'h00, "unmapped");
    $display("test irq and device select done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    host.rd(`RSC_OFF_STATUS, v);
    chk(v, 8'h40, "reset status");
    t_status();
    t_save();
    t_abort();
    t_standby();
    t_irq_dev();
    conclude();
  end
endmodule
